// ### src/dmm_mult.sv
`timescale 1ns/1ps
`include "dmm_cfg.svh"
module dmm_mult
  import dmm_pkg::*;
#(
  parameter int AW = `DMM_WIDE_W,
  parameter int NW = `DMM_NARROW_W
) (
  input  wire logic                   clk_sys_i,  // block clock
  input  wire logic                   rst_n_i,    // sync reset, low: loads zeros
  input  wire logic                   ena_i,      // shared clock enable
  input  wire logic                   aclr_i,     // asynchronous clear, high
  input  wire dmm_mode_t              mode_i,     // wide or narrow
  input  wire logic [`DMM_SEL_W-1:0]  reg_sel_i,  // per-stage register select
  input  wire logic [AW-1:0]          data_a_i,   // A: wide, or {A1,A0} narrow
  input  wire logic [AW-1:0]          data_b_i,   // B: wide, or {B1,B0} narrow
  input  wire logic                   sign_a_i,   // A treated signed when high
  input  wire logic                   sign_b_i,   // B treated signed when high
  output logic [2*AW-1:0]             result_o,   // wide product or {P1,P0}
  output logic                        result_signed_o // product is signed
);
  // =====================================================
  // clear and reset
  // the asynchronous clear goes straight to every stage; the reset stays
  // synchronous by forcing a load of zeros, so no gated logic ever drives
  // a clear pin and a glitch on the reset cannot wipe the pipeline
  logic clr;       // asynchronous clear of every stage
  logic ld_en;     // load strobe: enable, or reset forcing zeros in
  logic chk_off;   // clear or reset active: checks stand aside
  assign clr     = aclr_i;            // RL14
  assign ld_en   = ena_i | ~rst_n_i;  // RL14
  assign chk_off = aclr_i | ~rst_n_i;

  // =====================================================
  // input stages; halves are independent so narrow operands can differ
  logic [NW-1:0] a0_q, a1_q, b0_q, b1_q;
  logic          sa_q, sb_q;

  // operand A, low half: low wide bits, or A0 in narrow mode
  dmm_stage #(.W(NW)) u_a0 ( // RL3 RL7
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_A0]),
    .d_i       (rst_n_i ? data_a_i[NW-1:0] : '0),
    .q_o       (a0_q)
  );
  // operand A, high half: upper wide bits, or A1 in narrow mode
  dmm_stage #(.W(AW-NW)) u_a1 ( // RL3 RL7
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_A1]),
    .d_i       (rst_n_i ? data_a_i[AW-1:NW] : '0),
    .q_o       (a1_q)
  );
  // operand B, low half: low wide bits, or B0 in narrow mode
  dmm_stage #(.W(NW)) u_b0 ( // RL3 RL7
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_B0]),
    .d_i       (rst_n_i ? data_b_i[NW-1:0] : '0),
    .q_o       (b0_q)
  );
  // operand B, high half: upper wide bits, or B1 in narrow mode
  dmm_stage #(.W(AW-NW)) u_b1 ( // RL3 RL7
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_B1]),
    .d_i       (rst_n_i ? data_b_i[AW-1:NW] : '0),
    .q_o       (b1_q)
  );
  // sign controls get one optional stage to line up with registered data
  dmm_stage #(.W(1)) u_sa ( // RL5 RL10
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_SA]),
    .d_i       (rst_n_i & sign_a_i),
    .q_o       (sa_q)
  );
  dmm_stage #(.W(1)) u_sb ( // RL5 RL10
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_SB]),
    .d_i       (rst_n_i & sign_b_i),
    .q_o       (sb_q)
  );

  // =====================================================
  // multiplier stage: extend each operand by one bit per its sign control
  logic [AW-1:0]     wa, wb;
  logic [2*AW-1:0]   wprod, nprod;
  logic [2*NW-1:0]   np0, np1;
  logic signed [AW:0] wa_x, wb_x;
  logic signed [NW:0] a0_x, a1_x, b0_x, b1_x;
  logic signed [2*AW+1:0] wp_full;
  logic signed [2*NW+1:0] np0_full, np1_full;

  always_comb begin
    wa   = {a1_q, a0_q};
    wb   = {b1_q, b0_q};
    wa_x = {sa_q & wa[AW-1], wa}; // RL11 RL4
    wb_x = {sb_q & wb[AW-1], wb}; // RL11
    a0_x = {sa_q & a0_q[NW-1], a0_q}; // RL8
    a1_x = {sa_q & a1_q[NW-1], a1_q}; // RL8
    b0_x = {sb_q & b0_q[NW-1], b0_q}; // RL9 one sign for both B halves
    b1_x = {sb_q & b1_q[NW-1], b1_q};
    wp_full  = wa_x * wb_x; // RL2 RL12 full precision
    np0_full = a0_x * b0_x; // RL6
    np1_full = a1_x * b1_x; // RL6
    wprod = wp_full[2*AW-1:0];
    np0   = np0_full[2*NW-1:0];
    np1   = np1_full[2*NW-1:0];
    nprod = {np1, np0}; // RL13 18-bit section per product
  end

  // mode selects which product reaches the output register
  logic [2*AW-1:0] prod_sel;
  assign prod_sel = (mode_i == DMM_MODE_NARROW) ? nprod : wprod; // RL1

  // =====================================================
  // output stages: wide mode uses both halves, gated by P0 select
  logic [2*NW-1:0] p0_q, p1_q;
  logic            p1_use;
  logic            sg_q;
  assign p1_use = (mode_i == DMM_MODE_NARROW) ? reg_sel_i[`DMM_SEL_P1]
                                               : reg_sel_i[`DMM_SEL_P0];
  // product low section: P0 in narrow mode, low half of the wide product
  dmm_stage #(.W(2*NW)) u_p0 ( // RL7 RL13
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_P0]),
    .d_i       (rst_n_i ? prod_sel[2*NW-1:0] : '0),
    .q_o       (p0_q)
  );
  // product high section: P1 in narrow mode, upper half of the wide product
  dmm_stage #(.W(2*AW-2*NW)) u_p1 ( // RL7 RL13
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (p1_use),
    .d_i       (rst_n_i ? prod_sel[2*AW-1:2*NW] : '0),
    .q_o       (p1_q)
  );
  // the sign flag rides with the low product section so that it always
  // describes the product on show; narrow users should select P0, P1 alike
  dmm_stage #(.W(1)) u_sg ( // RL12
    .clk_i     (clk_sys_i),
    .ena_i     (ld_en),
    .aclr_i    (clr),
    .use_reg_i (reg_sel_i[`DMM_SEL_P0]),
    .d_i       (rst_n_i & (sa_q | sb_q)),
    .q_o       (sg_q)
  );

  // bypass paths must stay combinational, so outputs are not re-registered
  assign result_o        = {p1_q, p0_q}; // RL16
  assign result_signed_o = sg_q;         // RL12

  // =====================================================
  // checks
  // all_byp marks the fully combinational setting of the block
  int unsigned all_byp;
  assign all_byp = (reg_sel_i == '0) ? 1 : 0;

  // operand A low half loaded into its registered stage, still registered
  sequence a0_load_s;
    (reg_sel_i[`DMM_SEL_A0] && ena_i) ##1 reg_sel_i[`DMM_SEL_A0];
  endsequence
  // every stage registered while the enable is low, then still registered
  sequence frozen_s;
    (!ena_i && reg_sel_i == 8'hff) ##1 (reg_sel_i == 8'hff);
  endsequence
  // sign stages registered, flag output section bypassed, enable high
  sequence sign_load_s;
    (reg_sel_i[`DMM_SEL_SA] && reg_sel_i[`DMM_SEL_SB] && !reg_sel_i[`DMM_SEL_P0] && ena_i)
      ##1 (reg_sel_i[`DMM_SEL_SA] && reg_sel_i[`DMM_SEL_SB] && !reg_sel_i[`DMM_SEL_P0]);
  endsequence
  // wide unsigned operands into registered product stages, inputs bypassed
  sequence out_load_s;
    (reg_sel_i == 8'hc0 && ena_i && mode_i == DMM_MODE_WIDE && !sign_a_i && !sign_b_i)
      ##1 (reg_sel_i == 8'hc0);
  endsequence
  // reset seen with both product sections registered, still registered
  sequence reset_s;
    (!rst_n_i && reg_sel_i[`DMM_SEL_P0] && p1_use) ##1 (reg_sel_i[`DMM_SEL_P0] && p1_use);
  endsequence

  // fully bypassed products: wide unsigned, wide with both signed, narrow unsigned
  wide_comb_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL16
    (all_byp == 1 && mode_i == DMM_MODE_WIDE && !sign_a_i && !sign_b_i)
      |-> result_o == 36'(data_a_i) * 36'(data_b_i))
    else $error("wide unsigned bypass product wrong");
  wide_signed_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL4
    (all_byp == 1 && mode_i == DMM_MODE_WIDE && sign_a_i && sign_b_i)
      |-> $signed(result_o) == $signed(data_a_i) * $signed(data_b_i))
    else $error("wide signed bypass product wrong");
  narrow_comb_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL6
    (all_byp == 1 && mode_i == DMM_MODE_NARROW && !sign_a_i && !sign_b_i)
      |-> result_o == {18'(data_a_i[17:9]) * 18'(data_b_i[17:9]),
                       18'(data_a_i[8:0]) * 18'(data_b_i[8:0])})
    else $error("narrow unsigned bypass products wrong");

  // sign flag, bypassed and through its one register stage
  sign_flag_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL12
    (!reg_sel_i[`DMM_SEL_SA] && !reg_sel_i[`DMM_SEL_SB] && !reg_sel_i[`DMM_SEL_P0])
      |-> result_signed_o == (sign_a_i | sign_b_i))
    else $error("result sign flag wrong");
  sign_reg_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL10
    sign_load_s |-> result_signed_o == ($past(sign_a_i) | $past(sign_b_i)))
    else $error("registered sign flag late or wrong");

  // one cycle per registered stage, and nothing moves without the enable
  in_latency_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL15
    a0_load_s |-> a0_q == $past(data_a_i[NW-1:0]))
    else $error("input stage latency wrong");
  out_latency_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL3
    out_load_s |-> result_o == 36'($past(data_a_i)) * 36'($past(data_b_i)))
    else $error("output stage latency wrong");
  hold_ena_a: assert property (@(posedge clk_sys_i) disable iff (chk_off) // RL14
    frozen_s |-> $stable(result_o))
    else $error("registers changed without enable");

  // clear and reset must leave registered products at zero
  clear_zero_a: assert property (@(posedge clk_sys_i) // RL15
    (aclr_i && reg_sel_i[`DMM_SEL_P0] && p1_use) |-> result_o == '0)
    else $error("clear left a registered product");
  reset_zero_a: assert property (@(posedge clk_sys_i) // RL15
    reset_s |-> result_o == '0)
    else $error("reset left a registered product");
endmodule : dmm_mult

// ### common/dmm_cfg.svh
// Behaviour
// (RL1) one wide or two narrow multipliers
// (RL2) wide mode: 18x18 for 10-18 bit operands
// (RL3) wide: each operand, product optionally registered
// (RL4) wide: signed, unsigned or mixed operands
// (RL5) sign controls dynamic, each optionally registered
// (RL6) narrow mode: two independent 9x9 products
// (RL7) narrow: every operand, product independently registered
// (RL8) one A-sign control covers both A operands
// (RL9) driver keeps both B, both A alike
// (RL10) sign controls optionally registered once
// (RL11) high sign control means two's complement
// (RL12) product signed if any operand signed
// (RL13) outputs 36 bits wide, 18 per narrow
// (RL14) one clock, enable, clear for all
// (RL15) each stage one cycle; clear zeroes all
// (RL16) all bypassed: product is combinational
`ifndef DMM_CFG_SVH
`define DMM_CFG_SVH
// =====================================================
// widths
`define DMM_WIDE_W   18
`define DMM_NARROW_W 9
`define DMM_PROD_W   36
`define DMM_NPROD_W  18
// register-select bit positions in the stage mask
`define DMM_SEL_A0   0
`define DMM_SEL_A1   1
`define DMM_SEL_B0   2
`define DMM_SEL_B1   3
`define DMM_SEL_SA   4
`define DMM_SEL_SB   5
`define DMM_SEL_P0   6
`define DMM_SEL_P1   7
`define DMM_SEL_W    8
`endif

// ### common/dmm_pkg.sv
package dmm_pkg;
  // operating modes of the block
  typedef enum logic {
    DMM_MODE_WIDE,
    DMM_MODE_NARROW
  } dmm_mode_t;
endpackage : dmm_pkg

// ### src/dmm_stage.sv
`timescale 1ns/1ps
// optional register stage: registered or passed straight through
module dmm_stage #(
  parameter int W = 9
) (
  input  wire logic         clk_i,    // block clock
  input  wire logic         ena_i,    // shared clock enable
  input  wire logic         aclr_i,   // shared asynchronous clear, high
  input  wire logic         use_reg_i,// 1: registered, 0: bypass
  input  wire logic [W-1:0] d_i,      // data in
  output logic      [W-1:0] q_o       // data out
);
  logic [W-1:0] q_r;

  // =====================================================
  // storage; clear wins at once, regardless of the clock
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      q_r <= '0; // RL15
    end else if (ena_i) begin
      q_r <= d_i; // RL15
    end
  end

  assign q_o = use_reg_i ? q_r : d_i; // RL16
endmodule : dmm_stage

// ### verification/dmm_fabric.sv
`timescale 1ns/1ps
// ==========
// fabric-side driver: operands and sign controls, moved just after the edge
module dmm_fabric (
  input  wire logic        clk_sys_i, // block clock
  output logic      [17:0] data_a_o,  // operand a, or {a1,a0}
  output logic      [17:0] data_b_o,  // operand b, or {b1,b0}
  output logic             sign_a_o,  // a two's complement when high
  output logic             sign_b_o   // b two's complement when high
);
  initial begin
    data_a_o = '0;
    data_b_o = '0;
    sign_a_o = 1'b0;
    sign_b_o = 1'b0;
  end
  // one sign bit per side, so both narrow halves always share it
  task automatic put(input logic [17:0] a, b, input logic sa, sb);
    @(posedge clk_sys_i);
    #1;
    data_a_o = a;
    data_b_o = b;
    sign_a_o = sa;
    sign_b_o = sb;
  endtask : put
endmodule : dmm_fabric

// ### verification/test_dual_mode_embedded_multiplier.sv
`timescale 1ns/1ps
`include "dmm_cfg.svh"
// ==========
// random products through four stage settings (00, c0, 3f, ff), in both modes
module test_dual_mode_embedded_multiplier;
  typedef struct {logic [35:0] r; logic s; logic cs; int due;} dmm_note_t;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, aclr_i = 1'b0, sa, sb, rsg;
  dmm_pkg::dmm_mode_t mode_i = dmm_pkg::DMM_MODE_WIDE;
  // every stage registered through reset, so the reset zeros are visible
  logic [`DMM_SEL_W-1:0] reg_sel_i = 8'hff;
  logic ena_i = 1'b1;
  logic [17:0] a, b;
  logic [35:0] res;
  logic [7:0] sels[4] = '{8'h00, 8'hc0, 8'h3f, 8'hff};
  int lats[4] = '{0, 1, 1, 2};
  dmm_note_t q[$];
  int cyc = 0, failures = 0, cmp_count = 0, seed = 31393;
  initial forever #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  dmm_fabric fab (.clk_sys_i(clk_sys_i), .data_a_o(a), .data_b_o(b), .sign_a_o(sa),
    .sign_b_o(sb));
  dmm_mult dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ena_i(ena_i), .aclr_i(aclr_i),
    .mode_i(mode_i), .reg_sel_i(reg_sel_i), .data_a_i(a), .data_b_i(b), .sign_a_i(sa),
    .sign_b_i(sb), .result_o(res), .result_signed_o(rsg));
  // sign-extend each operand by its own control, keep full precision
  function automatic logic [35:0] prod(input logic [17:0] x, y, input logic s, t);
    logic signed [37:0] pw;
    logic signed [19:0] p0, p1;
    pw = $signed({s & x[17], x}) * $signed({t & y[17], y});
    p0 = $signed({s & x[8], x[8:0]}) * $signed({t & y[8], y[8:0]});
    p1 = $signed({s & x[17], x[17:9]}) * $signed({t & y[17], y[17:9]});
    return (mode_i == dmm_pkg::DMM_MODE_WIDE) ? pw[35:0] : {p1[17:0], p0[17:0]};
  endfunction : prod
  task automatic check(input string n, input logic [35:0] s, e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic complete_run;
    if (q.size() != 0) check("pending", 36'(q.size()), 36'h0);
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // results settle mid-cycle; every note due this cycle is compared, oldest first
  always @(negedge clk_sys_i) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      check("result", res, q[0].r);
      if (q[0].cs) check("signed", {35'h0, rsg}, {35'h0, q[0].s});
      void'(q.pop_front());
    end
  end
  initial begin : main
    logic [17:0] ra, rb;
    logic rs, rt;
    repeat (5) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    for (int m = 0; m < 2; m++) for (int c = 0; c < 4; c++) begin
      mode_i = dmm_pkg::dmm_mode_t'(m);
      reg_sel_i = sels[c];
      repeat (20) begin
        ra = 18'($random(seed));
        rb = 18'($random(seed));
        rs = 1'($random(seed));
        rt = 1'($random(seed));
        fab.put(ra, rb, rs, rt);
        q.push_back(dmm_note_t'{prod(ra, rb, rs, rt), rs | rt, 1'b1, cyc + lats[c]});
      end
      repeat (3) @(posedge clk_sys_i);
      #1;
    end
    // a low enable must freeze every stage while the operands move on
    ra = 18'($random(seed));
    rb = 18'($random(seed));
    fab.put(ra, rb, 1'b1, 1'b0);
    q.push_back(dmm_note_t'{prod(ra, rb, 1'b1, 1'b0), 1'b1, 1'b1, cyc + 2});
    repeat (2) @(posedge clk_sys_i);
    #1 ena_i = 1'b0;
    repeat (2) begin
      fab.put(~ra, ~rb, 1'b0, 1'b1);
      q.push_back(dmm_note_t'{prod(ra, rb, 1'b1, 1'b0), 1'b1, 1'b1, cyc});
    end
    ena_i = 1'b1;
    // clear must zero registered outputs at once, without an edge
    fab.put(18'h3ffff, 18'h3ffff, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    #1 aclr_i = 1'b1;
    q.push_back(dmm_note_t'{36'h0, 1'b0, 1'b0, cyc});
    @(posedge clk_sys_i);
    #1 aclr_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    complete_run();
  end
  // watchdog well past the expected ~200 cycles
  initial begin
    #100000;
    failures++;
    complete_run();
  end
endmodule : test_dual_mode_embedded_multiplier
